/* shared/hisr_pkg.sv */
/*
 Constants for the HID status report builder and the indirect register
 access decoder: report layout, flag positions, report identifiers and
 timing figures.
 Assumes a 100 MHz core clock.
*/
package hisr_pkg;
   // ===========================================================
   // Status report layout
   localparam int REP_LEN = 36;
   localparam int REP_HDR = 4;
   localparam int DATA_MAX = 32;
   localparam int FLAG_REQ_ERR = 0;
   localparam int FLAG_NACK = 1;
   localparam int FLAG_ARB = 2;
   localparam int FLAG_TMO = 3;
   localparam logic [7:0] RSVD_BYTE = 8'h00;
   // ===========================================================
   // Feature reports
   localparam logic [7:0] ID_REG_WRITE = 8'h3C;
   localparam logic [7:0] ID_RD_ADDR = 8'h4B;
   localparam logic [7:0] ID_REG_READ = 8'h5A;
   localparam logic [2:0] LEN_REG_WRITE = 3'h5;
   localparam logic [2:0] LEN_RD_ADDR = 3'h3;
   localparam logic [2:0] LEN_REG_READ = 3'h3;
   // ===========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUS_IDLE_MS = 256;
   localparam int BYTE_MS = 10;
   localparam int BUS_IDLE_CYC = BUS_IDLE_MS * (1000000 / CLK_PERIOD_NS);
   localparam int BYTE_CYC = BYTE_MS * (1000000 / CLK_PERIOD_NS);
   // ===========================================================
   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAITBUS = 4'h2,
      ST_XFER = 4'h4,
      ST_REPORT = 4'h8
   } hisr_state_t;
endpackage : hisr_pkg

/* core/hisr_feature.sv */
/*
 Decoder for the three control-endpoint feature reports: register write,
 read address load and register read.
 Assumes a whole report is presented for one cycle with its length, and
 that register contents answer combinationally to the read address.
*/
`timescale 1ns/1ps
module hisr_feature
   import hisr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic featValid,
   input wire logic [2:0] featLen,
   input wire logic [7:0] featId,
   input wire logic [7:0] featByte1,
   input wire logic [7:0] featByte2,
   input wire logic [7:0] featByte3,
   input wire logic [7:0] featByte4,
   input wire logic [15:0] regRdData,
   output logic regWrEn,
   output logic [15:0] regWrAddr,
   output logic [15:0] regWrData,
   output logic [15:0] regRdAddr,
   output logic featRdValid,
   output logic [7:0] featRdLo,
   output logic [7:0] featRdHi
);
   // ===========================================================
   // State
   typedef struct packed {
      logic wrEn;
      logic [15:0] wrAddr;
      logic [15:0] wrData;
      logic [15:0] rdAddr;
      logic rdValid;
      logic [15:0] rdData;
   } hisr_feat_t;

   hisr_feat_t s_q;
   hisr_feat_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.wrEn = 1'b0;
      s_d.rdValid = 1'b0;
      if (featValid) begin
         case (featId)
            ID_REG_WRITE: begin
               if (featLen == LEN_REG_WRITE) begin
                  s_d.wrEn = 1'b1;
                  s_d.wrAddr = {featByte2, featByte1};
                  s_d.wrData = {featByte4, featByte3};
               end
            end
            ID_RD_ADDR: begin
               if (featLen == LEN_RD_ADDR) begin
                  s_d.rdAddr = {featByte2, featByte1};
               end
            end
            ID_REG_READ: begin
               if (featLen == LEN_REG_READ) begin
                  s_d.rdValid = 1'b1;
                  s_d.rdData = regRdData;
               end
            end
            default: begin
               s_d.wrEn = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign regWrEn = s_q.wrEn;
   assign regWrAddr = s_q.wrAddr;
   assign regWrData = s_q.wrData;
   assign regRdAddr = s_q.rdAddr;
   assign featRdValid = s_q.rdValid;
   assign featRdLo = s_q.rdData[7:0];
   assign featRdHi = s_q.rdData[15:8];

   // ===========================================================
   // Checks
   default disable iff (!rstn);
   a_reg_write: assert property (@(posedge core_clk)
      featValid && featId == ID_REG_WRITE && featLen == LEN_REG_WRITE
      |=> regWrEn && regWrAddr == {$past(featByte2), $past(featByte1)}
          && regWrData == {$past(featByte4), $past(featByte3)})
      else $error("register write not issued as received");
   a_rdaddr_latch: assert property (@(posedge core_clk)
      featValid && featId == ID_RD_ADDR && featLen == LEN_RD_ADDR
      |=> regRdAddr == {$past(featByte2), $past(featByte1)} && !regWrEn)
      else $error("read address not latched");
   a_rd_return: assert property (@(posedge core_clk)
      featValid && featId == ID_REG_READ && featLen == LEN_REG_READ
      |=> featRdValid && {featRdHi, featRdLo} == $past(regRdData))
      else $error("register read data wrong");
   c_reg_read: cover property (@(posedge core_clk) disable iff (!rstn)
      featValid && featId == ID_RD_ADDR ##[1:20] featRdValid);
endmodule : hisr_feature

/* core/hisr_core.sv */
/*
 Top of the HID I2C status and register access block: runs one I2C
 command against the bus engine, builds the 36-byte status report and
 hosts the feature report decoder.
 Assumes the command parser hands over sizes and sequence number, the bus
 engine reports per-byte progress and faults, and the IN endpoint pulls
 report bytes with a ready signal.
*/
`timescale 1ns/1ps
// Functional notes
// - Every I2C command gets a fixed 36-byte status report.
// - Flag bit 0 marks a malformed command, which is not executed.
// - Target NACK aborts the transfer and sets flag bit 1.
// - Lost arbitration aborts the transfer and sets flag bit 2.
// - Flag bit 3 on no idle bus in 256 ms or slow byte.
// - Upper flag nibble echoes the command's sequence number.
// - Report byte one counts bytes written, 0 to 32.
// - Report byte two counts bytes read; byte three reserved.
// - Report always holds 32 data bytes; host trusts only counted ones.
// - Register write report 0x3C stores 16-bit data at 16-bit address.
// - Report 0x4B latches the address for later register reads.
// - Report 0x5A returns contents at latched address, low byte first.
// - Every command is followed by exactly one status report.
module hisr_core
   import hisr_pkg::*;
#(
   parameter int unsigned BUS_IDLE_CYCLES = BUS_IDLE_CYC,
   parameter int unsigned BYTE_CYCLES = BYTE_CYC
)(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cmdValid,
   input wire logic [3:0] cmdSeq,
   input wire logic [7:0] cmdWrSize,
   input wire logic [7:0] cmdRdSize,
   output logic cmdReady,
   input wire logic engBusIdle,
   input wire logic engByteDone,
   input wire logic engByteRd,
   input wire logic [7:0] engRdByte,
   input wire logic engNack,
   input wire logic engArbLost,
   input wire logic engDone,
   output logic engStart,
   output logic engAbort,
   output logic [5:0] engWrSize,
   output logic [5:0] engRdSize,
   output logic repValid,
   output logic [7:0] repByte,
   output logic repLast,
   input wire logic repReady,
   input wire logic featValid,
   input wire logic [2:0] featLen,
   input wire logic [7:0] featId,
   input wire logic [7:0] featByte1,
   input wire logic [7:0] featByte2,
   input wire logic [7:0] featByte3,
   input wire logic [7:0] featByte4,
   input wire logic [15:0] regRdData,
   output logic regWrEn,
   output logic [15:0] regWrAddr,
   output logic [15:0] regWrData,
   output logic [15:0] regRdAddr,
   output logic featRdValid,
   output logic [7:0] featRdLo,
   output logic [7:0] featRdHi
);
   // ===========================================================
   // State
   typedef struct packed {
      hisr_state_t st;
      logic [3:0] flags;
      logic [3:0] seq;
      logic [5:0] wrCnt;
      logic [5:0] rdCnt;
      logic [31:0] tmr;
      logic [5:0] idx;
      logic [DATA_MAX-1:0][7:0] rdData;
      logic engStart;
      logic engAbort;
      logic [5:0] engWrSize;
      logic [5:0] engRdSize;
      logic repValid;
      logic [7:0] repByte;
      logic repLast;
      logic cmdReady;
   } hisr_core_t;

   localparam logic [31:0] BUS_LIMIT = 32'(BUS_IDLE_CYCLES - 1);
   localparam logic [31:0] BYTE_LIMIT = 32'(BYTE_CYCLES - 1);
   localparam logic [5:0] LAST_IDX = 6'(REP_LEN - 1);
   localparam logic [7:0] SIZE_MAX = 8'(DATA_MAX);

   hisr_core_t s_q;
   hisr_core_t s_d;

   // Report byte at a given position
   function automatic logic [7:0] hisrByteAt(input logic [5:0] i,
                                             input hisr_core_t s);
      logic [5:0] j;
      j = i - 6'(REP_HDR);
      case (i)
         6'h00: hisrByteAt = {s.seq, s.flags};
         6'h01: hisrByteAt = {2'h0, s.wrCnt};
         6'h02: hisrByteAt = {2'h0, s.rdCnt};
         6'h03: hisrByteAt = RSVD_BYTE;
         default: hisrByteAt = s.rdData[j[4:0]];
      endcase
   endfunction : hisrByteAt

   // ===========================================================
   // Sequencer
   always_comb begin
      s_d = s_q;
      s_d.engStart = 1'b0;
      s_d.engAbort = 1'b0;
      case (s_q.st)
         ST_IDLE: begin
            if (cmdValid) begin
               s_d.seq = cmdSeq;
               s_d.flags = 4'h0;
               s_d.wrCnt = 6'h00;
               s_d.rdCnt = 6'h00;
               s_d.tmr = 32'h0;
               s_d.cmdReady = 1'b0;
               if (cmdWrSize > SIZE_MAX || cmdRdSize > SIZE_MAX) begin
                  s_d.flags[FLAG_REQ_ERR] = 1'b1;
                  s_d.st = ST_REPORT;
               end else begin
                  s_d.engWrSize = cmdWrSize[5:0];
                  s_d.engRdSize = cmdRdSize[5:0];
                  s_d.st = ST_WAITBUS;
               end
            end
         end
         ST_WAITBUS: begin
            if (engBusIdle) begin
               s_d.engStart = 1'b1;
               s_d.tmr = 32'h0;
               s_d.st = ST_XFER;
            end else if (s_q.tmr >= BUS_LIMIT) begin
               s_d.flags[FLAG_TMO] = 1'b1;
               s_d.st = ST_REPORT;
            end else begin
               s_d.tmr = s_q.tmr + 32'h1;
            end
         end
         ST_XFER: begin
            if (engNack) begin
               s_d.flags[FLAG_NACK] = 1'b1;
               s_d.engAbort = 1'b1;
               s_d.st = ST_REPORT;
            end else if (engArbLost) begin
               s_d.flags[FLAG_ARB] = 1'b1;
               s_d.engAbort = 1'b1;
               s_d.st = ST_REPORT;
            end else if (s_q.tmr >= BYTE_LIMIT) begin
               s_d.flags[FLAG_TMO] = 1'b1;
               s_d.engAbort = 1'b1;
               s_d.st = ST_REPORT;
            end else begin
               s_d.tmr = s_q.tmr + 32'h1;
               if (engByteDone) begin
                  s_d.tmr = 32'h0;
                  if (engByteRd && s_q.rdCnt < 6'(DATA_MAX)) begin
                     s_d.rdData[s_q.rdCnt[4:0]] = engRdByte;
                     s_d.rdCnt = s_q.rdCnt + 6'h01;
                  end else if (!engByteRd && s_q.wrCnt < 6'(DATA_MAX)) begin
                     s_d.wrCnt = s_q.wrCnt + 6'h01;
                  end
               end
               if (engDone) begin
                  s_d.st = ST_REPORT;
               end
            end
         end
         ST_REPORT: begin
            if (repReady) begin
               if (s_q.idx == LAST_IDX) begin
                  s_d.repValid = 1'b0;
                  s_d.repLast = 1'b0;
                  s_d.cmdReady = 1'b1;
                  s_d.st = ST_IDLE;
               end else begin
                  s_d.idx = s_q.idx + 6'h01;
                  s_d.repByte = hisrByteAt(s_q.idx + 6'h01, s_q);
                  s_d.repLast = (s_q.idx + 6'h01 == LAST_IDX);
               end
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
      // Load the first report byte on entry
      if (s_d.st == ST_REPORT && s_q.st != ST_REPORT) begin
         s_d.idx = 6'h00;
         s_d.repValid = 1'b1;
         s_d.repLast = 1'b0;
         s_d.repByte = hisrByteAt(6'h00, s_d);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.cmdReady <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign cmdReady = s_q.cmdReady;
   assign engStart = s_q.engStart;
   assign engAbort = s_q.engAbort;
   assign engWrSize = s_q.engWrSize;
   assign engRdSize = s_q.engRdSize;
   assign repValid = s_q.repValid;
   assign repByte = s_q.repByte;
   assign repLast = s_q.repLast;

   // ===========================================================
   // Feature reports
   hisr_feature u_feature (
      .core_clk(core_clk),
      .rstn(rstn),
      .featValid(featValid),
      .featLen(featLen),
      .featId(featId),
      .featByte1(featByte1),
      .featByte2(featByte2),
      .featByte3(featByte3),
      .featByte4(featByte4),
      .regRdData(regRdData),
      .regWrEn(regWrEn),
      .regWrAddr(regWrAddr),
      .regWrData(regWrData),
      .regRdAddr(regRdAddr),
      .featRdValid(featRdValid),
      .featRdLo(featRdLo),
      .featRdHi(featRdHi)
   );

   // ===========================================================
   // Checks
   logic [7:0] beatCnt;
   always_ff @(posedge core_clk) begin
      if (!rstn || (repValid && repReady && repLast)) begin
         beatCnt <= 8'h00;
      end else if (repValid && repReady) begin
         beatCnt <= beatCnt + 8'h01;
      end
   end
   default disable iff (!rstn);
   a_report_len: assert property (@(posedge core_clk)
      repValid && repReady && repLast |-> beatCnt == 8'(REP_LEN - 1))
      else $error("status report length is not 36");
   a_bad_size: assert property (@(posedge core_clk)
      cmdValid && cmdReady && (cmdWrSize > SIZE_MAX || cmdRdSize > SIZE_MAX)
      |=> repValid && repByte == {$past(cmdSeq), 4'h1} && !engStart)
      else $error("malformed command not refused");
   a_nack_abort: assert property (@(posedge core_clk)
      s_q.st == ST_XFER && engNack
      |=> engAbort && repValid && repByte[FLAG_NACK])
      else $error("nack did not abort");
   a_arb_abort: assert property (@(posedge core_clk)
      s_q.st == ST_XFER && engArbLost && !engNack
      |=> engAbort && repByte[FLAG_ARB] && !repByte[FLAG_NACK])
      else $error("lost arbitration did not abort");
   a_bus_tmo: assert property (@(posedge core_clk)
      s_q.st == ST_WAITBUS && !engBusIdle && s_q.tmr == BUS_LIMIT
      |=> repValid && repByte[FLAG_TMO] && !engStart)
      else $error("bus idle timeout missed");
   a_seq_echo: assert property (@(posedge core_clk)
      cmdValid && cmdReady |=> s_q.seq == $past(cmdSeq)
      && (!repValid || repByte[7:4] == $past(cmdSeq)))
      else $error("sequence number not echoed");
   a_count_range: assert property (@(posedge core_clk)
      repValid && repReady && s_q.idx == 6'h00
      |=> repByte == {2'h0, s_q.wrCnt} && repByte <= SIZE_MAX)
      else $error("written count out of range");
   a_report_follows: assert property (@(posedge core_clk)
      s_q.st == ST_XFER && engDone |=> repValid && repByte[7:4] == s_q.seq)
      else $error("no report after command");
   a_clean_flags: assert property (@(posedge core_clk)
      s_q.st == ST_XFER && engDone && !engNack && !engArbLost
      && s_q.tmr < BYTE_LIMIT |=> repByte[3:0] == 4'h0)
      else $error("fault flags set on clean command");
   c_clean_cmd: cover property (@(posedge core_clk) disable iff (!rstn)
      engStart ##[1:100] (repValid && repLast && repReady));
   c_bad_cmd: cover property (@(posedge core_clk) disable iff (!rstn)
      repValid && repByte[FLAG_REQ_ERR]);
   c_nack: cover property (@(posedge core_clk) disable iff (!rstn)
      engAbort && repByte[FLAG_NACK]);
endmodule : hisr_core

/* verification/hisr_eng_model.sv */
/*
 Behavioural bus engine at the far side of the command path.
 Assumes engStart pulses on core_clk and sizes valid with them.
*/
`timescale 1ns/1ps
module hisr_eng_model
   import hisr_pkg::*;
(
   input wire logic core_clk,
   input wire logic engStart,
   input wire logic [5:0] engWrSize,
   input wire logic [5:0] engRdSize,
   input wire logic [2:0] mode,
   output logic engBusIdle,
   output logic engByteDone,
   output logic engByteRd,
   output logic [7:0] engRdByte,
   output logic engNack,
   output logic engArbLost,
   output logic engDone,
   output int starts
);
   // ===========================================================
   // Modes: 0 clean, 1 nack, 2 arbitration, 3 stall, 4 bus busy
   int i;
   int n;
   initial begin
      {engByteDone, engByteRd, engNack, engArbLost, engDone} = '0;
      engRdByte = 8'h00;
      engBusIdle = 1'b1;
      starts = 0;
      forever begin
         @(posedge core_clk);
         engBusIdle <= (mode != 3'h4);
         if (engStart === 1'b1) begin
            starts++;
            n = int'(engWrSize) + int'(engRdSize);
            for (i = 0; i < n && mode == 3'h0; i++) begin
               repeat (2) @(posedge core_clk);
               engByteDone <= 1'b1;
               engByteRd <= (i >= int'(engWrSize));
               engRdByte <= 8'hA0 + 8'(i - int'(engWrSize));
               @(posedge core_clk);
               engByteDone <= 1'b0;
               engRdByte <= ~engRdByte;
            end
            repeat (2) @(posedge core_clk);
            engNack <= (mode == 3'h1);
            engArbLost <= (mode == 3'h2);
            engDone <= (mode == 3'h0);
            @(posedge core_clk);
            {engNack, engArbLost, engDone} <= 3'h0;
         end
      end
   end
endmodule : hisr_eng_model

/* verification/tb_hid_i2c_status_and_reg_access.sv */
/*
 Self-checking bench for the status report builder and feature decoder.
 Assumes the bus engine model beside it and shortened timeouts.
*/
`timescale 1ns/1ps
module tb_hid_i2c_status_and_reg_access;
   import hisr_pkg::*;
   logic core_clk, rstn, cmdValid, cmdReady, engBusIdle, engByteDone;
   logic engByteRd, engNack, engArbLost, engDone, engStart, engAbort;
   logic repValid, repLast, repReady, featValid, regWrEn, featRdValid;
   logic [3:0] cmdSeq;
   logic [7:0] cmdWrSize, cmdRdSize, engRdByte, repByte, featId;
   logic [7:0] featByte1, featByte2, featByte3, featByte4;
   logic [7:0] featRdLo, featRdHi;
   logic [5:0] engWrSize, engRdSize;
   logic [2:0] featLen, mode;
   logic [15:0] regRdData, regWrAddr, regWrData, regRdAddr;
   logic [7:0] rep [36];
   logic [3:0] expFlag [4] = '{4'h2, 4'h4, 4'h8, 4'h8};
   int num_errors, compares, starts, aborts, s0, a0, i;
   // ===========================================================
   // Design and engine model
   assign regRdData = regRdAddr ^ 16'h5A5A;
   hisr_core #(.BUS_IDLE_CYCLES(50), .BYTE_CYCLES(30)) dut_u (
      .core_clk(core_clk), .rstn(rstn), .cmdValid(cmdValid),
      .cmdSeq(cmdSeq), .cmdWrSize(cmdWrSize), .cmdRdSize(cmdRdSize),
      .cmdReady(cmdReady), .engBusIdle(engBusIdle),
      .engByteDone(engByteDone), .engByteRd(engByteRd),
      .engRdByte(engRdByte), .engNack(engNack), .engArbLost(engArbLost),
      .engDone(engDone), .engStart(engStart), .engAbort(engAbort),
      .engWrSize(engWrSize), .engRdSize(engRdSize), .repValid(repValid),
      .repByte(repByte), .repLast(repLast), .repReady(repReady),
      .featValid(featValid), .featLen(featLen), .featId(featId),
      .featByte1(featByte1), .featByte2(featByte2),
      .featByte3(featByte3), .featByte4(featByte4),
      .regRdData(regRdData), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
      .regWrData(regWrData), .regRdAddr(regRdAddr),
      .featRdValid(featRdValid), .featRdLo(featRdLo), .featRdHi(featRdHi));
   hisr_eng_model eng_u (
      .core_clk(core_clk), .engStart(engStart), .engWrSize(engWrSize),
      .engRdSize(engRdSize), .mode(mode), .engBusIdle(engBusIdle),
      .engByteDone(engByteDone), .engByteRd(engByteRd),
      .engRdByte(engRdByte), .engNack(engNack), .engArbLost(engArbLost),
      .engDone(engDone), .starts(starts));
   always @(posedge core_clk) begin
      if (engAbort === 1'b1) aborts++;
   end
   // ===========================================================
   // Tasks
   task automatic cmp(input logic [15:0] got, exp, input string m);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : cmp
   task automatic run_cmd(input logic [3:0] s, input logic [7:0] w, r,
                          input logic [2:0] md);
      int k;
      int n;
      @(posedge core_clk);
      mode <= md;
      cmdValid <= 1'b1;
      cmdSeq <= s;
      cmdWrSize <= w;
      cmdRdSize <= r;
      @(posedge core_clk);
      cmdValid <= 1'b0;
      for (k = 0; k < 36; k++) begin
         n = 0;
         @(negedge core_clk);
         while (repValid !== 1'b1 && n < 500) begin
            n++;
            @(negedge core_clk);
         end
         cmp(16'(repValid), 16'h0001, "report missing");
         rep[k] = repByte;
         cmp(16'(repLast), 16'(k == 35), "last flag");
      end
      @(negedge core_clk);
      cmp(16'(repValid), 16'h0000, "extra report");
      cmp(16'(cmdReady), 16'h0001, "not ready");
   endtask : run_cmd
   task automatic feat(input logic [7:0] id, input logic [2:0] len,
                       input logic [7:0] b1, b2, b3, b4);
      @(posedge core_clk);
      featValid <= 1'b1;
      featId <= id;
      featLen <= len;
      featByte1 <= b1;
      featByte2 <= b2;
      featByte3 <= b3;
      featByte4 <= b4;
      @(posedge core_clk);
      featValid <= 1'b0;
      @(negedge core_clk);
   endtask : feat
   task automatic tally_and_finish;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // ===========================================================
   // Clock, watchdog and tests
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      {rstn, cmdValid, featValid} = 3'h0;
      repReady = 1'b1;
      mode = 3'h0;
      cmdSeq = 4'h0;
      {cmdWrSize, cmdRdSize, featId} = '0;
      {featByte1, featByte2, featByte3, featByte4} = '0;
      featLen = 3'h0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      run_cmd(4'h5, 8'h02, 8'h03, 3'h0);
      cmp(16'(rep[0]), 16'h0050, "flags clean");
      cmp(16'(rep[1]), 16'h0002, "written count");
      cmp(16'(rep[2]), 16'h0003, "read count");
      cmp(16'(rep[3]), 16'h0000, "reserved byte");
      for (i = 0; i < 3; i++)
         cmp(16'(rep[4 + i]), 16'(8'hA0 + i), "read data");
      run_cmd(4'hF, 8'h20, 8'h20, 3'h0);
      cmp(16'(rep[0]), 16'h00F0, "flags full");
      cmp({rep[1], rep[2]}, 16'h2020, "full counts");
      cmp(16'(rep[35]), 16'h00BF, "last data");
      for (i = 0; i < 2; i++) begin
         s0 = starts;
         run_cmd(4'h3, i ? 8'h00 : 8'h21, i ? 8'h21 : 8'h00, 3'h0);
         cmp(16'(rep[0]), 16'h0031, "bad size flag");
         cmp(16'(starts), 16'(s0), "bad size ran");
      end
      for (i = 0; i < 4; i++) begin
         a0 = aborts;
         run_cmd(4'(i + 8), 8'h02, 8'h01, 3'(i + 1));
         cmp(16'(rep[0]), {8'h00, 4'(i + 8), expFlag[i]}, "fault flag");
         cmp(16'(aborts), 16'(a0 + (i < 3)), "abort");
      end
      feat(ID_REG_WRITE, LEN_REG_WRITE,
           8'h41, 8'h03, 8'hEF, 8'hBE);
      cmp(16'(regWrEn), 16'h0001, "write strobe");
      cmp(regWrAddr, 16'h0341, "write address");
      cmp(regWrData, 16'hBEEF, "write data");
      feat(ID_REG_WRITE, 3'h3, 8'h41, 8'h03, 8'hEF, 8'hBE);
      cmp(16'(regWrEn), 16'h0000, "short write");
      feat(ID_RD_ADDR, LEN_RD_ADDR,
           8'hC2, 8'h03, 8'h00, 8'h00);
      cmp(regRdAddr, 16'h03C2, "read address");
      feat(ID_REG_READ, LEN_REG_READ,
           8'h00, 8'h00, 8'h00, 8'h00);
      cmp(16'(featRdValid), 16'h0001, "read strobe");
      cmp({featRdHi, featRdLo}, 16'h5998, "read data");
      feat(ID_REG_READ, 3'h5, 8'h00, 8'h00, 8'h00, 8'h00);
      cmp(16'(featRdValid), 16'h0000, "long read");
      tally_and_finish();
   end
endmodule : tb_hid_i2c_status_and_reg_access
